//--- src/mcr_pkg.sv
/*
  Shared constants and types for the macrocell register block: register
  offsets, configuration layout, pin carrier and clock-mode enumeration.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit bus.
*/
package mcr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // Configuration word
  localparam logic [7:0] ADDR_STAT    = 8'h04;  // Live state, read only
  localparam logic [7:0] ADDR_PT_BASE = 8'h40;  // First product-term word
  localparam logic [7:0] ADDR_PT_END  = 8'hB0;  // One past the last
  localparam logic [3:0] PT_PAGE_BASE = 4'h4;   // ADDR_PT_BASE page index

  // Product-term word selects within one 16-byte term slot
  localparam logic [1:0] PT_SEL_TLO = 2'h0;     // True mask, low word
  localparam logic [1:0] PT_SEL_THI = 2'h1;     // True mask, high bits
  localparam logic [1:0] PT_SEL_CLO = 2'h2;     // Complement mask, low
  localparam logic [1:0] PT_SEL_CHI = 2'h3;     // Complement mask, high

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int LAB_IN_W = 36;                 // Interconnect inputs
  localparam int PT_HI_W  = LAB_IN_W - 32;      // Mask bits above word 0
  localparam int PT_NUM   = 7;                  // Five own, two expanders
  localparam int PT_SUM0  = 0;                  // Sum term
  localparam int PT_SUM1  = 1;                  // Sum term
  localparam int PT_CLK   = 2;                  // Clock enable / array clock
  localparam int PT_PRE   = 3;                  // Preset
  localparam int PT_CLR   = 4;                  // Clear
  localparam int PT_SHR   = 5;                  // Shareable expander
  localparam int PT_PAR   = 6;                  // Parallel expander

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;                 // Core clock rate
  localparam int LPA_NS  = 10;                  // Low-power delay adder
  localparam int LPA_CYC = (LPA_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MCR_CLK_GLOBAL,                             // Plain global clock
    MCR_CLK_GATED,                              // Global clock with enable
    MCR_CLK_ARRAY                               // Product-term clock
  } mcr_clk_mode_e;

  typedef struct packed {
    logic          par_en;        // Add parallel expander to the sum
    logic          shr_en;        // Add shareable expander to the sum
    logic          test_port_en;  // Test port owns the pin
    logic          out_en;        // Pin output enable
    logic          open_drain;    // Drive low only
    logic          low_power;     // Slow, low-power path
    logic          fast_en;       // Pin feeds D directly, enhanced only
    logic          gclr_en;       // Global clear pin may clear
    logic          gclk_pick;     // Use global clock B instead of A
    logic          gb_inv;        // Global clock B inverted
    logic          gb_pin;        // Global clock B from pin two
    logic          ga_inv;        // Global clock A inverted
    logic          ga_pin;        // Global clock A from pin two
    logic          enhanced;      // Enhanced variant features on
    mcr_clk_mode_e clk_mode;      // Register clock mode
    logic          seq_en;        // Registered output
  } mcr_cfg_s;

  localparam mcr_cfg_s CFG_RST = '0;            // Configuration at reset
  localparam int       CFG_W   = $bits(mcr_cfg_s);

  typedef struct packed {
    logic gclk_one;                             // Global clock pin one
    logic gclk_two;                             // Global clock pin two
    logic gclr_low;                             // Global clear, active low
    logic fast_in;                              // Fast input pin
  } mcr_pin_s;

endpackage

//--- src/mcr_macrocell.sv
/*
  One macrocell of a logic array block with its programmable register,
  product terms, expanders, speed/power option and pin driver, all set
  up over APB. Assumes pins are asynchronous to clk and that the
  interconnect inputs come from logic on clk.
*/
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Cell works combinational or registered
// - Register clock mode chosen of three
// - Gated mode loads only with enable high
// - Array mode clocks from a product term
// - Small variant uses pin one clock only
// - Enhanced: two clocks, any pin, either polarity
// - Product-term preset and clear, active high
// - Global clear pin optionally clears register
// - Register is zero after power-up
// - Enhanced: fast pin path straight to D
// - Five own terms plus block expanders
// - Inputs from interconnect plus global controls
// - Low-power mode adds delay to the sum path
// - Optional open-drain pin output
// - Test port takes the pin over
module mcr_macrocell (
  // Clock, reset and freeze
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output      logic [31:0]                  prdata,
  output      logic                         pready,
  output      logic                         pslverr,
  // Interconnect inputs
  input  wire logic [mcr_pkg::LAB_IN_W-1:0] lab_in,
  // Dedicated and fast input pins
  input  wire mcr_pkg::mcr_pin_s            pins,
  // I/O pin driver
  output      logic                         pin_o,
  output      logic                         pin_oe,
  output      logic                         test_port_active
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    mcr_pkg::mcr_cfg_s                                  cfg;
    logic [mcr_pkg::PT_NUM-1:0][mcr_pkg::LAB_IN_W-1:0] pt_true;
    logic [mcr_pkg::PT_NUM-1:0][mcr_pkg::LAB_IN_W-1:0] pt_comp;
    mcr_pkg::mcr_pin_s                                  sync1;
    mcr_pkg::mcr_pin_s                                  sync2;
    logic                                               gclk_prev;
    logic                                               aclk_prev;
    logic                                               sum_lp;
    logic                                               q;
    logic [31:0]                                        prdata;
    logic                                               pin_o;
    logic                                               pin_oe;
  } mcr_state_s;

  mcr_state_s st_ff;                          // Registered state
  mcr_state_s nxt_st;                         // Next state

  logic [mcr_pkg::PT_NUM-1:0] pt_val;         // Product-term values
  logic                       sum_raw;        // Sum before speed option
  logic                       sum_path;       // Sum after speed option
  logic                       gclk_a;         // Global clock A
  logic                       gclk_b;         // Global clock B
  logic                       gclk_sel;       // Clock seen by register
  logic                       gedge;          // Global clock rising
  logic                       aedge;          // Array clock rising
  logic                       clr_now;        // Clear active
  logic                       pre_now;        // Preset active
  logic                       load_now;       // Register loads D
  logic                       d_in;           // Register D input
  logic                       out_val;        // Value toward the pin
  logic [2:0]                 idx;            // Addressed term

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Product term: AND of selected true and complemented inputs;
  // an unprogrammed term is low
  function automatic logic pt_eval(
    input logic [mcr_pkg::LAB_IN_W-1:0] t,
    input logic [mcr_pkg::LAB_IN_W-1:0] c,
    input logic [mcr_pkg::LAB_IN_W-1:0] x);
    pt_eval = ((t | c) != '0) && (&((x | ~t) & (~x | ~c)));
  endfunction

  // Term index from a product-term address
  function automatic logic [2:0] pt_idx(input logic [7:0] a);
    pt_idx = 3'(a[7:4] - mcr_pkg::PT_PAGE_BASE);
  endfunction

  // Address lies in the map
  function automatic logic addr_ok(input logic [7:0] a);
    if (a == mcr_pkg::ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (a == mcr_pkg::ADDR_STAT) begin
      addr_ok = 1'b1;
    end else if (a >= mcr_pkg::ADDR_PT_BASE &&
                 a <  mcr_pkg::ADDR_PT_END) begin
      addr_ok = a[1:0] == 2'h0;
    end else begin
      addr_ok = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Product terms and sum
  // ----------------------------------------------------------------------
  // Every term, own and expander, looks at the interconnect inputs
  genvar g;
  generate
    for (g = 0; g < mcr_pkg::PT_NUM; g++) begin : g_pt
      assign pt_val[g] = pt_eval(st_ff.pt_true[g], st_ff.pt_comp[g],
                                 lab_in);
    end
  endgenerate

  // Shareable expander comes back inverted, parallel one as is
  assign sum_raw = pt_val[mcr_pkg::PT_SUM0] | pt_val[mcr_pkg::PT_SUM1]
                 | (st_ff.cfg.shr_en & ~pt_val[mcr_pkg::PT_SHR])
                 | (st_ff.cfg.par_en &  pt_val[mcr_pkg::PT_PAR]);

  // Low-power cells see the sum one adder later
  assign sum_path = st_ff.cfg.low_power ? st_ff.sum_lp
                                        : sum_raw;

  // ----------------------------------------------------------------------
  // Register clocking
  // ----------------------------------------------------------------------
  // Global clocks pick a pin and a polarity
  assign gclk_a = (st_ff.cfg.ga_pin ? st_ff.sync2.gclk_two
                                    : st_ff.sync2.gclk_one)
                ^ st_ff.cfg.ga_inv;
  assign gclk_b = (st_ff.cfg.gb_pin ? st_ff.sync2.gclk_two
                                    : st_ff.sync2.gclk_one)
                ^ st_ff.cfg.gb_inv;

  // Small variant: pin one, true, nothing else
  assign gclk_sel = !st_ff.cfg.enhanced ? st_ff.sync2.gclk_one
                  : (st_ff.cfg.gclk_pick ? gclk_b : gclk_a);

  assign gedge = gclk_sel & ~st_ff.gclk_prev;
  assign aedge = pt_val[mcr_pkg::PT_CLK] & ~st_ff.aclk_prev;

  // Clear beats preset when both are asked for
  assign clr_now = pt_val[mcr_pkg::PT_CLR]
                 | (st_ff.cfg.gclr_en & ~st_ff.sync2.gclr_low);
  assign pre_now = pt_val[mcr_pkg::PT_PRE];

  // Fast pin path skips interconnect and sum
  assign d_in = (st_ff.cfg.enhanced & st_ff.cfg.fast_en)
              ? st_ff.sync2.fast_in : sum_path;

  // Load condition by clock mode
  always_comb begin
    case (st_ff.cfg.clk_mode)
      mcr_pkg::MCR_CLK_GLOBAL: begin
        load_now = gedge;
      end
      mcr_pkg::MCR_CLK_GATED: begin
        load_now = gedge & pt_val[mcr_pkg::PT_CLK];
      end
      mcr_pkg::MCR_CLK_ARRAY: begin
        load_now = aedge;
      end
      default: begin
        load_now = 1'b0;
      end
    endcase
  end

  // Combinational or registered toward the pin
  assign out_val = st_ff.cfg.seq_en ? st_ff.q : sum_path;
  assign idx     = pt_idx(paddr);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Two flops on every pin before use
    nxt_st.sync1     = pins;
    nxt_st.sync2     = st_ff.sync1;
    nxt_st.gclk_prev = gclk_sel;
    nxt_st.aclk_prev = pt_val[mcr_pkg::PT_CLK];
    nxt_st.sum_lp    = sum_raw;

    // Register: clear, then preset, then clocked load
    if (clr_now) begin
      nxt_st.q = 1'b0;
    end else if (pre_now) begin
      nxt_st.q = 1'b1;
    end else if (load_now) begin
      nxt_st.q = d_in;
    end

    // Pin driver
    if (st_ff.cfg.test_port_en) begin
      nxt_st.pin_o  = 1'b0;
      nxt_st.pin_oe = 1'b0;
    end else if (st_ff.cfg.open_drain) begin
      nxt_st.pin_o  = 1'b0;
      nxt_st.pin_oe = st_ff.cfg.out_en & ~out_val;
    end else begin
      nxt_st.pin_o  = out_val;
      nxt_st.pin_oe = st_ff.cfg.out_en;
    end

    // Read data is captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      if (paddr == mcr_pkg::ADDR_CTRL) begin
        nxt_st.prdata = {{(32-mcr_pkg::CFG_W){1'b0}}, st_ff.cfg};
      end else if (paddr == mcr_pkg::ADDR_STAT) begin
        nxt_st.prdata = {26'h0, st_ff.sync2, st_ff.q, sum_path};
      end else if (addr_ok(paddr)) begin
        case (paddr[3:2])
          mcr_pkg::PT_SEL_TLO: begin
            nxt_st.prdata = st_ff.pt_true[idx][31:0];
          end
          mcr_pkg::PT_SEL_THI: begin
            nxt_st.prdata = {{(32-mcr_pkg::PT_HI_W){1'b0}},
                             st_ff.pt_true[idx][mcr_pkg::LAB_IN_W-1:32]};
          end
          mcr_pkg::PT_SEL_CLO: begin
            nxt_st.prdata = st_ff.pt_comp[idx][31:0];
          end
          default: begin
            nxt_st.prdata = {{(32-mcr_pkg::PT_HI_W){1'b0}},
                             st_ff.pt_comp[idx][mcr_pkg::LAB_IN_W-1:32]};
          end
        endcase
      end else begin
        nxt_st.prdata = 32'h0000_0000;
      end
    end

    // Writes take effect in the access cycle
    if (psel && penable && pwrite) begin
      if (paddr == mcr_pkg::ADDR_CTRL) begin
        nxt_st.cfg = mcr_pkg::mcr_cfg_s'(pwdata[mcr_pkg::CFG_W-1:0]);
      end else if (addr_ok(paddr) && paddr != mcr_pkg::ADDR_STAT) begin
        case (paddr[3:2])
          mcr_pkg::PT_SEL_TLO: begin
            nxt_st.pt_true[idx][31:0] = pwdata;
          end
          mcr_pkg::PT_SEL_THI: begin
            nxt_st.pt_true[idx][mcr_pkg::LAB_IN_W-1:32] =
              pwdata[mcr_pkg::PT_HI_W-1:0];
          end
          mcr_pkg::PT_SEL_CLO: begin
            nxt_st.pt_comp[idx][31:0] = pwdata;
          end
          default: begin
            nxt_st.pt_comp[idx][mcr_pkg::LAB_IN_W-1:32] =
              pwdata[mcr_pkg::PT_HI_W-1:0];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Everything, the macrocell register included, powers up at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata           = st_ff.prdata;
  assign pready           = psel & penable;
  assign pslverr          = psel & penable & ~addr_ok(paddr);
  assign pin_o            = st_ff.pin_o;
  assign pin_oe           = st_ff.pin_oe;
  assign test_port_active = st_ff.cfg.test_port_en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_clear_to_zero: assert property (
    ce && clr_now |=> st_ff.q == 1'b0)
    else $error("clear did not zero the register");

  a_preset_to_one: assert property (
    ce && pre_now && !clr_now |=> st_ff.q == 1'b1)
    else $error("preset did not set the register");

  a_global_clear: assert property (
    ce && st_ff.cfg.gclr_en && !st_ff.sync2.gclr_low |=> !st_ff.q)
    else $error("global clear pin ignored");

  a_gated_load: assert property (
    ce && st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_GATED && gedge &&
    pt_val[mcr_pkg::PT_CLK] && !clr_now && !pre_now
    |=> st_ff.q == $past(d_in))
    else $error("gated global clock did not load");

  a_gated_hold: assert property (
    ce && st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_GATED &&
    !pt_val[mcr_pkg::PT_CLK] && !clr_now && !pre_now
    |=> $stable(st_ff.q))
    else $error("register moved with enable low");

  a_array_load: assert property (
    ce && st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_ARRAY && aedge &&
    !clr_now && !pre_now |=> st_ff.q == $past(d_in))
    else $error("array clock did not load");

  a_small_clock: assert property (
    ce && !st_ff.cfg.enhanced && !st_ff.sync2.gclk_one &&
    st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_GLOBAL &&
    !clr_now && !pre_now |=> $stable(st_ff.q))
    else $error("small variant used another clock");

  a_comb_output: assert property (
    ce && !st_ff.cfg.seq_en && st_ff.cfg.out_en &&
    !st_ff.cfg.open_drain && !st_ff.cfg.test_port_en
    |=> pin_o == $past(sum_path) && pin_oe)
    else $error("combinational output wrong");

  a_open_drain: assert property (
    ce && st_ff.cfg.open_drain && !st_ff.cfg.test_port_en
    |=> !pin_o && pin_oe == $past(st_ff.cfg.out_en & ~out_val))
    else $error("open drain drove high");

  a_test_takeover: assert property (
    ce && st_ff.cfg.test_port_en |=> !pin_oe)
    else $error("pin driven while test port owns it");

  a_low_power_lag: assert property (
    ce && st_ff.cfg.low_power ##1 st_ff.cfg.low_power
    |-> sum_path == $past(sum_raw))
    else $error("low power path not delayed");

  c_gated_load: cover property (
    st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_GATED && ce && load_now);
  c_array_load: cover property (
    st_ff.cfg.clk_mode == mcr_pkg::MCR_CLK_ARRAY && ce && load_now);
  c_open_low: cover property (st_ff.cfg.open_drain && pin_oe);
  c_preset: cover property (ce && pre_now && !clr_now);

endmodule

//--- verif/mcr_far_model.sv
/*
  Far side of the macrocell: interconnect drivers and device pins.
  Assumes the bench calls its tasks from the clk domain.
*/
`timescale 1ns/1ps

module mcr_far_model (
  // Clock
  input  wire logic              clk,
  // Pin driver of the cell
  input  wire logic              pin_o,
  input  wire logic              pin_oe,
  // Toward the cell
  output      logic [35:0]       lab_ff,
  output      mcr_pkg::mcr_pin_s pins_ff,
  output      logic              pin_wire
);
  // Wired-OR line with pull-up: released pin reads high
  assign pin_wire = pin_oe ? pin_o : 1'b1;

  // Idle levels: clocks low, global clear released
  initial begin
    lab_ff  = 36'h0;
    pins_ff = 4'h2;
  end

  // Interconnect inputs, changed just after an edge
  task automatic set_lab(input logic [35:0] v);
    @(posedge clk);
    lab_ff <= v;
  endtask

  // Clock pin levels {two, one}
  task automatic set_clk(input logic [1:0] v);
    @(posedge clk);
    pins_ff.gclk_two <= v[1];
    pins_ff.gclk_one <= v[0];
  endtask

  // Global clear and fast input levels
  task automatic set_ctl(input logic gclr_low, input logic fast);
    @(posedge clk);
    pins_ff.gclr_low <= gclr_low;
    pins_ff.fast_in  <= fast;
  endtask
endmodule

//--- verif/testbench.sv
/*
  Self-checking bench for the macrocell: APB master tasks and one task
  per scenario. Assumes the far-side model drives pins and lab_in.
*/
`timescale 1ns/1ps

module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk, nrst, ce, psel, penable, pwrite;
  logic              pready, pslverr, pin_o, pin_oe, tpa, pin_wire;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [35:0]       lab_in;
  logic              err;
  mcr_pkg::mcr_pin_s pins;
  int                n_fail, comparisons;

  mcr_macrocell u_dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lab_in(lab_in),
    .pins(pins), .pin_o(pin_o), .pin_oe(pin_oe), .test_port_active(tpa));

  mcr_far_model u_far (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .lab_ff(lab_in), .pins_ff(pins), .pin_wire(pin_wire));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask

  // One APB transfer; waits for pready under a bounded count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no pready", $time);
      print_verdict();
    end
  endtask

  // Register q as seen in the status word
  task automatic q_is(input logic e);
    apb(1'b0, 8'h04, 32'h0);
    chk_bit(rd[1], e);
  endtask

  task automatic wait_pins(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Clock pin pulse: high for four cycles, then low
  task automatic pulse(input logic [1:0] v);
    u_far.set_clk(v);
    repeat (3) @(posedge clk);
    u_far.set_clk(2'b00);
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h0);
    q_is(1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0);
    chk_bit(pin_oe, 1'b0);
    $display("test reset done");
  endtask

  // Terms: 0 sum on bit0, 2 clock on bit1, 3 preset bit2, 4 clear bit3
  task automatic t_comb();
    apb(1'b1, 8'h40, 32'h1);
    apb(1'b1, 8'h60, 32'h2);
    apb(1'b1, 8'h70, 32'h4);
    apb(1'b1, 8'h80, 32'h8);
    apb(1'b1, 8'h00, 32'h2000);
    u_far.set_lab(36'h1);
    wait_pins(4);
    chk_bit(pin_o, 1'b1);
    chk_bit(pin_wire, 1'b1);
    u_far.set_lab(36'h0);
    wait_pins(4);
    chk_bit(pin_o, 1'b0);
    $display("test comb done");
  endtask

  task automatic t_global();
    apb(1'b1, 8'h00, 32'h2001);
    u_far.set_lab(36'h1);
    pulse(2'b10);
    q_is(1'b0);
    pulse(2'b01);
    q_is(1'b1);
    wait_pins(2);
    chk_bit(pin_o, 1'b1);
    $display("test global done");
  endtask

  task automatic t_clr_pre();
    apb(1'b1, 8'h00, 32'h2201);
    u_far.set_lab(36'h9);
    u_far.set_lab(36'h1);
    q_is(1'b0);
    u_far.set_lab(36'h5);
    u_far.set_lab(36'h1);
    q_is(1'b1);
    u_far.set_ctl(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    u_far.set_ctl(1'b1, 1'b0);
    q_is(1'b0);
    $display("test clear preset done");
  endtask

  task automatic t_gated();
    apb(1'b1, 8'h00, 32'h2003);
    pulse(2'b01);
    q_is(1'b0);
    u_far.set_lab(36'h3);
    pulse(2'b01);
    q_is(1'b1);
    $display("test gated done");
  endtask

  task automatic t_array();
    u_far.set_lab(36'h0);
    apb(1'b1, 8'h00, 32'h2005);
    pulse(2'b01);
    q_is(1'b1);
    u_far.set_lab(36'h2);
    repeat (4) @(posedge clk);
    q_is(1'b0);
    $display("test array done");
  endtask

  // Clock A = inverted pin two, D from the fast pin
  task automatic t_enh();
    apb(1'b1, 8'h00, 32'h2439);
    u_far.set_ctl(1'b1, 1'b1);
    u_far.set_clk(2'b10);
    repeat (5) @(posedge clk);
    q_is(1'b0);
    u_far.set_clk(2'b00);
    repeat (5) @(posedge clk);
    q_is(1'b1);
    // Clock B = true pin one; pin two must not clock it
    u_far.set_ctl(1'b1, 1'b0);
    apb(1'b1, 8'h00, 32'h2509);
    pulse(2'b10);
    q_is(1'b1);
    pulse(2'b01);
    q_is(1'b0);
    $display("test enhanced done");
  endtask

  // Expanders: term 5 on bit4 (inverted), term 6 on bit5; low power on
  task automatic t_power();
    apb(1'b1, 8'h90, 32'h10);
    apb(1'b1, 8'hA0, 32'h20);
    u_far.set_lab(36'h10);
    apb(1'b1, 8'h00, 32'h1A800);
    wait_pins(4);
    chk_bit(pin_o, 1'b0);
    u_far.set_lab(36'h30);
    wait_pins(1);
    chk_bit(pin_o, 1'b0);
    wait_pins(0);
    chk_bit(pin_o, 1'b1);
    u_far.set_lab(36'h10);
    wait_pins(4);
    chk_bit(pin_o, 1'b0);
    u_far.set_lab(36'h0);
    wait_pins(4);
    chk_bit(pin_o, 1'b1);
    // Frozen cell ignores its inputs until the enable returns
    @(posedge clk);
    ce <= 1'b0;
    u_far.set_lab(36'h10);
    wait_pins(3);
    chk_bit(pin_o, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    wait_pins(3);
    chk_bit(pin_o, 1'b0);
    $display("test power done");
  endtask

  task automatic t_pin();
    apb(1'b1, 8'h00, 32'h3000);
    u_far.set_lab(36'h1);
    wait_pins(4);
    chk_bit(pin_oe, 1'b0);
    chk_bit(pin_wire, 1'b1);
    u_far.set_lab(36'h0);
    wait_pins(4);
    chk_bit(pin_wire, 1'b0);
    apb(1'b1, 8'h00, 32'h7000);
    wait_pins(3);
    chk_bit(pin_oe, 1'b0);
    chk_bit(tpa, 1'b1);
    $display("test pin done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0;
    ce = 1'b1;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    n_fail = 0; comparisons = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_comb();
    t_global();
    t_clr_pre();
    t_gated();
    t_array();
    t_enh();
    t_power();
    t_pin();
    print_verdict();
  end
endmodule
